// File: design/ccmvm_core.sv
// Design: call mode selection, vector fetch and memory map decoding
`timescale 1ns/1ps

// Summary of operation
// - Bit 3 of stack bank mode select picks compact or extended mode.
// - Reset loads the select register with bit 3 set: compact mode.
// - Value 1000B means compact mode, 0000B means extended mode.
// - Direct and fast calls push two stack bytes in compact mode, three in extended; table call reports none.
// - Absolute long branch and call are legal only in extended mode.
// - Direct call 3/4 cycles, fast call 2/3 cycles, compact/extended.
// - The select register is written whole as one 4-bit unit.
// - After reset start address and bank flags come from 0000H-0001H.
// - Interrupt vectors with bank flags are read from 0002H-000DH.
// - Table call entries lie in program memory 0020H-007FH.
// - Table call hands back its entry address; running the entry is left to the requester.
// - Program memory holds 2048 or 4096 bytes by variant.
// - Data storage is 256 nibbles at 000H-0FFH.
// - Peripheral registers are 128 nibbles at F80H-FFFH.
// - Register pair table branch replaces only the low eight PC bits.
module ccmvm_core #(
  parameter bit LARGE_ROM = 1'b1
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // Select register access
  input  wire logic                          sbs_we,
  input  wire logic [ccmvm_pkg::SBS_W-1:0]   sbs_wdata,
  output logic      [ccmvm_pkg::SBS_W-1:0]   sbs_rdata,
  output logic                               compact_call_mode,
  // Instruction request and answer
  input  wire logic                          req_valid,
  input  wire ccmvm_pkg::ccmvm_req_t         req,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output ccmvm_pkg::ccmvm_rsp_t              rsp,
  output logic                               start_valid,
  // Program memory read port, data one cycle after address
  output logic      [ccmvm_pkg::PC_W-1:0]    rom_addr,
  input  wire logic [7:0]                    rom_rdata,
  // Data memory decode
  input  wire logic [ccmvm_pkg::DA_W-1:0]    dm_addr,
  output logic                               dm_is_data,
  output logic                               dm_is_periph
);

  // ==========================================================================
  // Local types
  typedef enum logic [1:0] {
    ST_VEC_HI,
    ST_VEC_LO,
    ST_VEC_END,
    ST_IDLE
  } ccmvm_state_t;

  localparam logic [ccmvm_pkg::PC_W-1:0] ROM_MASK =
    LARGE_ROM ? ccmvm_pkg::PC_W'(ccmvm_pkg::ROM_WORDS_LARGE - 1)
              : ccmvm_pkg::PC_W'(ccmvm_pkg::ROM_WORDS_SMALL - 1);

  // Last address of the reset vector; only the start fetch ends there
  localparam logic [ccmvm_pkg::PC_W-1:0] START_LAST =
    ccmvm_pkg::VEC_RESET_BASE + ccmvm_pkg::PC_W'(1);

  // ==========================================================================
  // Mode register
  logic [ccmvm_pkg::SBS_W-1:0] sbs_r;
  logic [ccmvm_pkg::SBS_W-1:0] sbs_nxt;

  always_comb begin
    sbs_nxt = sbs_r;
    if (sbs_we) begin
      sbs_nxt = sbs_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sbs_r <= ccmvm_pkg::SBS_RESET;
    end else begin
      sbs_r <= sbs_nxt;
    end
  end

  // Requests see the registered mode, so a write in the same cycle counts
  // only from the next instruction on
  logic mode_cmp;
  assign mode_cmp          = sbs_r[ccmvm_pkg::SBS_MODE_BIT];
  assign compact_call_mode = mode_cmp;
  assign sbs_rdata         = sbs_r;

  // ==========================================================================
  // Request handling and vector fetch
  ccmvm_state_t               state_r;
  ccmvm_state_t               state_nxt;
  logic [ccmvm_pkg::PC_W-1:0] rom_addr_r;
  logic [ccmvm_pkg::PC_W-1:0] rom_addr_nxt;
  logic [7:0]                 vec_hi_r;
  logic [7:0]                 vec_hi_nxt;
  logic                       rsp_valid_r;
  logic                       rsp_valid_nxt;
  logic                       start_r;
  logic                       start_nxt;
  ccmvm_pkg::ccmvm_rsp_t      rsp_r;
  ccmvm_pkg::ccmvm_rsp_t      rsp_nxt;

  assign req_ready = (state_r == ST_IDLE);

  always_comb begin
    logic [ccmvm_pkg::PC_W-1:0] vec_target;
    vec_target    = {vec_hi_r[3:0], rom_rdata} & ROM_MASK;
    state_nxt     = state_r;
    rom_addr_nxt  = rom_addr_r;
    vec_hi_nxt    = vec_hi_r;
    rsp_valid_nxt = 1'b0;
    start_nxt     = 1'b0;
    rsp_nxt       = rsp_r;
    unique case (state_r)
      ST_VEC_HI: begin
        rom_addr_nxt = rom_addr_r + ccmvm_pkg::PC_W'(1);
        state_nxt    = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        vec_hi_nxt = rom_rdata;
        state_nxt  = ST_VEC_END;
      end
      ST_VEC_END: begin
        // Start address and bank flags loaded together
        rsp_nxt.target = vec_target;
        rsp_nxt.register_bank_enable_flag    = vec_hi_r[ccmvm_pkg::VEC_RBE_BIT];
        rsp_nxt.memory_bank_enable_flag    = vec_hi_r[ccmvm_pkg::VEC_MBE_BIT];
        rsp_nxt.illegal = 1'b0;
        if (rom_addr_r == START_LAST) begin
          start_nxt = 1'b1;
        end else begin
          rsp_valid_nxt = 1'b1;
        end
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (req_valid) begin
          rsp_valid_nxt       = 1'b1;
          rsp_nxt.illegal     = 1'b0;
          rsp_nxt.stack_bytes = 2'h0;
          rsp_nxt.cycles      = 3'h1;
          rsp_nxt.target      = req.pc;
          unique case (req.op)
            ccmvm_pkg::OP_DIRECT_CALL: begin
              rsp_nxt.stack_bytes = mode_cmp ? ccmvm_pkg::STK_COMPACT
                                    : ccmvm_pkg::STK_EXTENDED;
              rsp_nxt.cycles = mode_cmp ? ccmvm_pkg::CYC_CALL_CMP
                                        : ccmvm_pkg::CYC_CALL_EXT;
            end
            ccmvm_pkg::OP_FAST_CALL: begin
              rsp_nxt.stack_bytes = mode_cmp ? ccmvm_pkg::STK_COMPACT
                                    : ccmvm_pkg::STK_EXTENDED;
              rsp_nxt.cycles = mode_cmp ? ccmvm_pkg::CYC_FCALL_CMP
                                        : ccmvm_pkg::CYC_FCALL_EXT;
            end
            ccmvm_pkg::OP_ABSOLUTE_LONG_BRANCH: begin
              rsp_nxt.illegal = mode_cmp;
            end
            ccmvm_pkg::OP_ABSOLUTE_LONG_CALL: begin
              rsp_nxt.illegal     = mode_cmp;
              rsp_nxt.stack_bytes = mode_cmp ? 2'h0
                                    : ccmvm_pkg::STK_EXTENDED;
            end
            ccmvm_pkg::OP_ONE_BYTE_TABLE_CALL: begin
              // Only the entry address is handed back; running that entry and
              // resuming after the table call are left to the requester
              if (req.arg[5:0] < ccmvm_pkg::TBL_ENTRIES) begin
                rsp_nxt.target = ccmvm_pkg::TBL_BASE +
                                 ccmvm_pkg::PC_W'({req.arg[5:0], 1'b0});
              end else begin
                rsp_nxt.illegal = 1'b1;
              end
            end
            ccmvm_pkg::OP_TABLE_BRANCH_PAIR: begin
              rsp_nxt.target = {req.pc[ccmvm_pkg::PC_W-1:8], req.arg}
                               & ROM_MASK;
            end
            ccmvm_pkg::OP_INT_VECTOR: begin
              if (req.arg[2:0] < ccmvm_pkg::INT_SOURCES) begin
                rsp_valid_nxt = 1'b0;
                rom_addr_nxt  = ccmvm_pkg::VEC_INT_BASE +
                                ccmvm_pkg::PC_W'({req.arg[2:0], 1'b0});
                state_nxt     = ST_VEC_HI;
              end else begin
                rsp_nxt.illegal = 1'b1;
              end
            end
            default: begin
              rsp_nxt.illegal = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= ST_VEC_HI;
      rom_addr_r  <= ccmvm_pkg::VEC_RESET_BASE;
      vec_hi_r    <= 8'h00;
      rsp_valid_r <= 1'b0;
      start_r     <= 1'b0;
      rsp_r       <= '0;
    end else begin
      state_r     <= state_nxt;
      rom_addr_r  <= rom_addr_nxt;
      vec_hi_r    <= vec_hi_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      start_r     <= start_nxt;
      rsp_r       <= rsp_nxt;
    end
  end

  assign rom_addr    = rom_addr_r;
  assign rsp_valid   = rsp_valid_r;
  assign start_valid = start_r;
  assign rsp         = rsp_r;

  // ==========================================================================
  // Data memory decode, registered
  logic dm_data_r;
  logic dm_data_nxt;
  logic dm_periph_r;
  logic dm_periph_nxt;

  always_comb begin
    dm_data_nxt   = (dm_addr <= ccmvm_pkg::DM_DATA_HI);
    dm_periph_nxt = (dm_addr >= ccmvm_pkg::DM_PERIPH_LO);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dm_data_r   <= 1'b0;
      dm_periph_r <= 1'b0;
    end else begin
      dm_data_r   <= dm_data_nxt;
      dm_periph_r <= dm_periph_nxt;
    end
  end

  assign dm_is_data   = dm_data_r;
  assign dm_is_periph = dm_periph_r;

endmodule : ccmvm_core

// File: include/ccmvm_pkg.sv
// Package: constants, enums and carriers for the call mode and vector map
package ccmvm_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W   = 12;
  localparam int DA_W   = 12;
  localparam int SBS_W  = 4;

  // ==========================================================================
  // Stack bank mode select register
  localparam int              SBS_MODE_BIT   = 3;
  localparam logic [SBS_W-1:0] SBS_RESET     = 4'h8;
  localparam logic [SBS_W-1:0] SBS_COMPACT   = 4'h8;
  localparam logic [SBS_W-1:0] SBS_EXTENDED  = 4'h0;

  // ==========================================================================
  // Stack use and machine cycles per mode
  localparam logic [1:0] STK_COMPACT     = 2'h2;
  localparam logic [1:0] STK_EXTENDED    = 2'h3;
  localparam logic [2:0] CYC_CALL_CMP    = 3'h3;
  localparam logic [2:0] CYC_CALL_EXT    = 3'h4;
  localparam logic [2:0] CYC_FCALL_CMP   = 3'h2;
  localparam logic [2:0] CYC_FCALL_EXT   = 3'h3;

  // ==========================================================================
  // Program memory map
  localparam int               ROM_WORDS_SMALL = 2048;
  localparam int               ROM_WORDS_LARGE = 4096;
  localparam logic [PC_W-1:0]  VEC_RESET_BASE  = 12'h000;
  localparam logic [PC_W-1:0]  VEC_INT_BASE    = 12'h002;
  localparam logic [PC_W-1:0]  VEC_INT_LAST    = 12'h00d;
  localparam logic [2:0]       INT_SOURCES     = 3'h6;
  localparam logic [PC_W-1:0]  TBL_BASE        = 12'h020;
  localparam logic [PC_W-1:0]  TBL_LAST        = 12'h07f;
  localparam logic [5:0]       TBL_ENTRIES     = 6'h30;
  // Vector word 0 layout: flags in the top bits, address high part below
  localparam int               VEC_MBE_BIT     = 7;
  localparam int               VEC_RBE_BIT     = 6;

  // ==========================================================================
  // Data memory map
  localparam logic [DA_W-1:0]  DM_DATA_LO      = 12'h000;
  localparam logic [DA_W-1:0]  DM_DATA_HI      = 12'h0ff;
  localparam logic [DA_W-1:0]  DM_PERIPH_LO    = 12'hf80;
  localparam logic [DA_W-1:0]  DM_PERIPH_HI    = 12'hfff;

  // ==========================================================================
  // Instruction classes handled here
  typedef enum logic [2:0] {
    OP_DIRECT_CALL,
    OP_FAST_CALL,
    OP_ABSOLUTE_LONG_BRANCH,
    OP_ABSOLUTE_LONG_CALL,
    OP_ONE_BYTE_TABLE_CALL,
    OP_TABLE_BRANCH_PAIR,
    OP_INT_VECTOR
  } ccmvm_op_t;

  typedef struct packed {
    ccmvm_op_t       op;
    logic [7:0]      arg;
    logic [PC_W-1:0] pc;
  } ccmvm_req_t;

  typedef struct packed {
    logic            illegal;
    logic [1:0]      stack_bytes;
    logic [2:0]      cycles;
    logic [PC_W-1:0] target;
    logic            register_bank_enable_flag;
    logic            memory_bank_enable_flag;
  } ccmvm_rsp_t;

endpackage : ccmvm_pkg

// File: testbench/ccmvm_core_asserts.sv
// Checker: call mode, call cost, branch and decode timing properties
`timescale 1ns/1ps
module ccmvm_core_asserts #(
  parameter bit LARGE_ROM = 1'b1
) (
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        rst,
  // Select register
  input wire logic                        sbs_we,
  input wire logic [ccmvm_pkg::SBS_W-1:0] sbs_wdata,
  input wire logic [ccmvm_pkg::SBS_W-1:0] sbs_rdata,
  input wire logic                        compact_call_mode,
  // Requests and answers
  input wire logic                        req_valid,
  input wire ccmvm_pkg::ccmvm_req_t       req,
  input wire logic                        req_ready,
  input wire logic                        rsp_valid,
  input wire ccmvm_pkg::ccmvm_rsp_t       rsp,
  input wire logic                        start_valid,
  // Memories
  input wire logic [ccmvm_pkg::PC_W-1:0]  rom_addr,
  input wire logic [7:0]                  rom_rdata,
  input wire logic [ccmvm_pkg::DA_W-1:0]  dm_addr,
  input wire logic                        dm_is_data,
  input wire logic                        dm_is_periph
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic taken;
  assign taken = req_valid && req_ready;
  // ==========================================================================
  // Properties
  a_mode_bit_track: assert property (
    compact_call_mode == sbs_rdata[3])
    else $error("mode flag differs from select bit 3");
  a_reg_write_whole: assert property (
    sbs_we |=> sbs_rdata == $past(sbs_wdata))
    else $error("select register write not stored whole");
  a_direct_call_cost: assert property (
    taken && req.op == ccmvm_pkg::OP_DIRECT_CALL |=> rsp_valid
    && rsp.stack_bytes == ($past(compact_call_mode) ? 2'h2 : 2'h3)
    && rsp.cycles == ($past(compact_call_mode) ? 3'h3 : 3'h4))
    else $error("direct call cost wrong for mode");
  a_fast_call_cost: assert property (
    taken && req.op == ccmvm_pkg::OP_FAST_CALL |=> rsp_valid
    && rsp.cycles == ($past(compact_call_mode) ? 3'h2 : 3'h3))
    else $error("fast call cycles wrong for mode");
  a_long_op_legal: assert property (
    taken && req.op == ccmvm_pkg::OP_ABSOLUTE_LONG_BRANCH |=> rsp_valid
    && rsp.illegal == $past(compact_call_mode))
    else $error("long branch legality wrong for mode");
  a_table_branch_low: assert property (
    taken && req.op == ccmvm_pkg::OP_TABLE_BRANCH_PAIR |=>
    rsp.target == ({$past(req.pc[11:8]), $past(req.arg)}
                   & (LARGE_ROM ? 12'hfff : 12'h7ff)))
    else $error("table branch changed upper pc bits");
  a_vector_fetch_seq: assert property (
    taken && req.op == ccmvm_pkg::OP_INT_VECTOR && req.arg[2:0] < 3'h6
    |=> rom_addr == 12'h002 + {$past(req.arg[2:0]), 1'b0} ##3 rsp_valid)
    else $error("vector entry address or timing wrong");
  // The edge that releases reset still loads reset flags, so skip it
  a_data_map_decode: assert property (
    !$past(rst) |-> dm_is_data == ($past(dm_addr) <= 12'h0ff)
    && dm_is_periph == ($past(dm_addr) >= 12'hf80))
    else $error("data memory decode wrong");
  // Back-to-back requests may answer on consecutive cycles
  a_answer_pulse: assert property (
    rsp_valid && !taken |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  c_extended_call: cover property (taken && !compact_call_mode);
  c_vector_done: cover property (taken && req.op == ccmvm_pkg::OP_INT_VECTOR ##4 rsp_valid);
  c_start_seen: cover property (start_valid);
endmodule : ccmvm_core_asserts

bind ccmvm_core ccmvm_core_asserts #(.LARGE_ROM(LARGE_ROM)) u_chk (
  .clock(clock), .rst(rst), .sbs_we(sbs_we), .sbs_wdata(sbs_wdata),
  .sbs_rdata(sbs_rdata), .compact_call_mode(compact_call_mode),
  .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .start_valid(start_valid),
  .rom_addr(rom_addr), .rom_rdata(rom_rdata), .dm_addr(dm_addr),
  .dm_is_data(dm_is_data), .dm_is_periph(dm_is_periph)
);

// File: testbench/cpu_call_mode_and_vector_map_test.sv
// Testbench: directed checks of mode, call costs, vectors and decode
`timescale 1ns/1ps
module cpu_call_mode_and_vector_map_test;
  logic                  clock;
  logic                  rst;
  logic                  sbs_we;
  logic [3:0]            sbs_wdata;
  logic [3:0]            sbs_rdata;
  logic                  compact_call_mode;
  logic                  req_valid;
  ccmvm_pkg::ccmvm_req_t req;
  logic                  req_ready;
  logic                  rsp_valid;
  ccmvm_pkg::ccmvm_rsp_t rsp;
  logic                  start_valid;
  logic [11:0]           rom_addr;
  logic [7:0]            rom_rdata;
  logic [11:0]           dm_addr;
  logic                  dm_is_data;
  logic                  dm_is_periph;
  int                    mismatches;
  int                    check_count;
  int                    i;

  ccmvm_core #(.LARGE_ROM(1'b1)) dut (
    .clock(clock), .rst(rst), .sbs_we(sbs_we), .sbs_wdata(sbs_wdata),
    .sbs_rdata(sbs_rdata), .compact_call_mode(compact_call_mode),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .start_valid(start_valid),
    .rom_addr(rom_addr), .rom_rdata(rom_rdata), .dm_addr(dm_addr),
    .dm_is_data(dm_is_data), .dm_is_periph(dm_is_periph)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Program memory: vectors at 000/001 and 004/005, filler elsewhere
  function automatic logic [7:0] rom_byte(input logic [11:0] a);
    case (a)
      12'h000: rom_byte = 8'hc5;
      12'h001: rom_byte = 8'h3a;
      12'h004: rom_byte = 8'h45;
      12'h005: rom_byte = 8'h67;
      default: rom_byte = a[7:0] ^ 8'ha5;
    endcase
  endfunction : rom_byte

  always @(posedge clock) rom_rdata <= rom_byte(rom_addr);

  task automatic summarize();
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic write_sbs(input logic [3:0] v);
    @(posedge clock);
    sbs_we <= 1'b1;
    sbs_wdata <= v;
    @(posedge clock);
    sbs_we <= 1'b0;
    #1;
  endtask : write_sbs

  // Hold the request until ready is seen at an edge, then wait the answer
  task automatic run(input ccmvm_pkg::ccmvm_op_t op, input logic [7:0] arg,
                     input logic [11:0] pc);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, arg: arg, pc: pc};
    for (n = 0; n < 10 && !req_ready; n++) @(negedge clock);
    if (n == 10) begin
      mismatches++;
      summarize();
    end
    @(posedge clock);
    req_valid <= 1'b0;
    for (n = 0; n < 10; n++) begin
      #1;
      if (rsp_valid === 1'b1) break;
      @(posedge clock);
    end
    if (n == 10) begin
      mismatches++;
      summarize();
    end
  endtask : run

  // Direct, fast, long branch and long call in the current mode
  task automatic call_set(input logic cmp);
    run(ccmvm_pkg::OP_DIRECT_CALL, 8'h00, 12'h100);
    check({rsp.stack_bytes, rsp.cycles}, cmp ? 5'h13 : 5'h1c);
    run(ccmvm_pkg::OP_FAST_CALL, 8'h00, 12'h100);
    check({rsp.stack_bytes, rsp.cycles}, cmp ? 5'h12 : 5'h1b);
    run(ccmvm_pkg::OP_ABSOLUTE_LONG_BRANCH, 8'h00, 12'h100);
    check(rsp.illegal, cmp);
    run(ccmvm_pkg::OP_ABSOLUTE_LONG_CALL, 8'h00, 12'h100);
    check({rsp.illegal, rsp.stack_bytes}, cmp ? 3'h4 : 3'h3);
  endtask : call_set

  initial begin
    mismatches = 0;
    check_count = 0;
    rst = 1'b1;
    sbs_we = 1'b0;
    sbs_wdata = 4'h0;
    req_valid = 1'b0;
    req = '0;
    dm_addr = 12'h000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 20 && start_valid !== 1'b1; i++) @(posedge clock) #1;
    check(i < 20, 1'b1);
    check({sbs_rdata, compact_call_mode}, 5'h11);
    check({rsp.target, rsp.register_bank_enable_flag, rsp.memory_bank_enable_flag}, {12'h53a, 2'b11});
    call_set(1'b1);
    write_sbs(4'h0);
    check({sbs_rdata, compact_call_mode}, 5'h00);
    call_set(1'b0);
    // Table call: entry 5 is ten bytes from base, 48 is past the area
    run(ccmvm_pkg::OP_ONE_BYTE_TABLE_CALL, 8'h05, 12'h300);
    check({rsp.illegal, rsp.target}, {1'b0, 12'h02a});
    run(ccmvm_pkg::OP_ONE_BYTE_TABLE_CALL, 8'h30, 12'h300);
    check(rsp.illegal, 1'b1);
    run(ccmvm_pkg::OP_TABLE_BRANCH_PAIR, 8'h12, 12'h7ff);
    check(rsp.target, 12'h712);
    run(ccmvm_pkg::OP_INT_VECTOR, 8'h01, 12'h200);
    check({rsp.target, rsp.register_bank_enable_flag, rsp.memory_bank_enable_flag}, {12'h567, 2'b10});
    run(ccmvm_pkg::OP_INT_VECTOR, 8'h06, 12'h200);
    check(rsp.illegal, 1'b1);
    write_sbs(4'h8);
    check({sbs_rdata, compact_call_mode}, 5'h11);
    call_set(1'b1);
    // Data map boundaries
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      dm_addr <= (i == 0) ? 12'h0ff : (i == 1) ? 12'h100 :
                 (i == 2) ? 12'hf7f : 12'hf80;
      @(posedge clock);
      @(posedge clock) #1;
      check({dm_is_data, dm_is_periph}, (i == 0) ? 2'b10 :
            (i == 3) ? 2'b01 : 2'b00);
    end
    summarize();
  end
endmodule : cpu_call_mode_and_vector_map_test
